// ===== logic/adc_cfg_pkg.sv
// constants and types for the global configuration and test register set
// assumes a byte-wide register port fed by the serial engine outside
package adc_cfg_pkg;

	// register addresses
	localparam logic [7:0] ADDR_PORT_CFG  = 8'h00;
	localparam logic [7:0] ADDR_ADVANCE   = 8'h71;
	localparam logic [7:0] ADDR_DIVISOR   = 8'h72;
	localparam logic [7:0] ADDR_FORMAT    = 8'h73;
	localparam logic [7:0] ADDR_DDR_LOOP  = 8'h74;
	localparam logic [7:0] ADDR_XOR_KEY   = 8'h75;
	localparam logic [7:0] ADDR_PAT_SEL   = 8'hC0;
	localparam logic [7:0] ADDR_W1_LOW    = 8'hC2;
	localparam logic [7:0] ADDR_W1_HIGH   = 8'hC3;
	localparam logic [7:0] ADDR_W2_LOW    = 8'hC4;
	localparam logic [7:0] ADDR_W2_HIGH   = 8'hC5;

	// field positions
	localparam int SOFT_RESET_BIT = 5;
	localparam int ADVANCE_BIT    = 0;
	localparam int DLL_SLOW_BIT   = 6;
	localparam int DDR_EN_BIT     = 4;
	localparam int KIND_LSB       = 5;
	localparam int PMODE_LSB      = 6;

	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;

	// three-bit select codes, all-zero pin code and one-hot choices, shared by divisor, kind and coding
	localparam logic [2:0] SEL_PIN = 3'b000;
	localparam logic [2:0] SEL_A   = 3'b001;
	localparam logic [2:0] SEL_B   = 3'b010;
	localparam logic [2:0] SEL_C   = 3'b100;

	// tri-level pin levels after the input comparator
	localparam logic [1:0] PIN_LOW  = 2'b00;
	localparam logic [1:0] PIN_MID  = 2'b01;
	localparam logic [1:0] PIN_HIGH = 2'b10;

	// pattern select codes
	localparam logic [3:0] PAT_OFF      = 4'h0;
	localparam logic [3:0] PAT_MID      = 4'h1;
	localparam logic [3:0] PAT_ONES     = 4'h2;
	localparam logic [3:0] PAT_ZEROS    = 4'h3;
	localparam logic [3:0] PAT_CHECKER  = 4'h4;
	localparam logic [3:0] PAT_ONE_ZERO = 4'h7;
	localparam logic [3:0] PAT_USER     = 4'h8;
	localparam logic [1:0] PMODE_STATIC = 2'b00;
	localparam logic [1:0] PMODE_ALT    = 2'b01;

	// fixed pattern words
	localparam logic [15:0] WORD_MID   = 16'h8000;
	localparam logic [15:0] WORD_ONES  = 16'hFFFF;
	localparam logic [15:0] WORD_ZEROS = 16'h0000;
	localparam logic [15:0] WORD_CHK1  = 16'hAAAA;
	localparam logic [15:0] WORD_CHK2  = 16'h5555;

	typedef enum logic [1:0] {DIV_BY1, DIV_BY2, DIV_BY4} divisor_t;
	typedef enum logic [1:0] {KIND_DIFF2, KIND_DIFF3, KIND_CMOS} kind_t;
	typedef enum logic [1:0] {CODE_TWOS, CODE_GRAY, CODE_BINARY} coding_t;

endpackage : adc_cfg_pkg

// ===== logic/sample_path_if.sv
// settings and timing shared between the register set and its helpers
// assumes all parties run on the same clock
`timescale 1ns/100ps
interface sample_path_if;
	import adc_cfg_pkg::*;

	divisor_t    divisor;    // effective divisor
	logic        slipReq;    // one-cycle advance request
	logic        sampleEn;   // one pulse per divided sample period
	logic        divClk;     // divided clock level
	logic [1:0]  patMode;    // static or alternate
	logic [3:0]  patSel;     // pattern choice
	logic [15:0] userWord1;  // first user word
	logic [15:0] userWord2;  // second user word
	logic [15:0] testWord;   // pattern on the output bus
	logic        testActive; // pattern drives the bus

	modport regs (output divisor, slipReq, patMode, patSel, userWord1,
		userWord2, input sampleEn, divClk, testWord, testActive);
	modport divider (input divisor, slipReq, output sampleEn, divClk);
	modport pattern (input sampleEn, patMode, patSel, userWord1,
		userWord2, output testWord, testActive);

endinterface : sample_path_if

// ===== logic/clock_divider_slip.sv
// divided sample timing with single-cycle phase advance in divide-by-four only
// assumes clk is the input sample clock and reset is already synchronised
`timescale 1ns/100ps
module clock_divider_slip
	import adc_cfg_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rstLocal_n,
	sample_path_if.divider path
);

	typedef struct packed {
		logic [1:0] count;   // position inside the divided period
		logic       enable;  // sample pulse
		logic       level;   // divided clock
	} div_state_t;

	div_state_t stateQ;  // registered state
	div_state_t stateD;  // next state

	// in divide-by-four, count advances by two on a slip so the rising edge comes a cycle early
	always_comb begin
		stateD = stateQ;
		case (path.divisor)
			DIV_BY4: begin
				if (path.slipReq) begin
					stateD.count = stateQ.count + 2'd2; // see [RQ1]
				end else begin
					stateD.count = stateQ.count + 2'd1;
				end
				stateD.level  = stateD.count[1];
				// pulse on the divided rising edge, so a skip past two
				// still yields its sample instead of dropping one
				stateD.enable = stateD.count[1] & ~stateQ.count[1];
			end
			DIV_BY2: begin
				stateD.count  = {1'b0, ~stateQ.count[0]};
				stateD.level  = stateD.count[0];
				stateD.enable = stateD.count[0];
			end
			default: begin
				// undivided: every edge samples, level just toggles
				stateD.count  = 2'd0;
				stateD.level  = ~stateQ.level;
				stateD.enable = 1'b1;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			stateQ <= '0;
		end else begin
			stateQ <= stateD;
		end
	end

	assign path.sampleEn = stateQ.enable;
	assign path.divClk   = stateQ.level;

endmodule : clock_divider_slip

// ===== logic/test_pattern_gen.sv
// built-in output test pattern source
// assumes sampleEn marks each divided sample period
`timescale 1ns/100ps
module test_pattern_gen
	import adc_cfg_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rstLocal_n,
	sample_path_if.pattern path
);

	typedef struct packed {
		logic        phase;  // which word of an alternating pair
		logic [15:0] word;   // word on the bus
		logic        active; // pattern enabled
	} pat_state_t;

	pat_state_t  stateQ;  // registered state
	pat_state_t  stateD;  // next state
	logic [15:0] wordOne; // first word of the pattern
	logic [15:0] wordTwo; // second word
	logic        valid;   // selection names a real pattern
	logic        altMode; // alternate between words

	// pattern table; reserved selections leave the bus alone
	always_comb begin
		wordOne = WORD_ZEROS;
		wordTwo = WORD_ZEROS;
		valid   = 1'b1;
		case (path.patSel) // see [RQ15]
			PAT_MID: begin
				wordOne = WORD_MID;
				wordTwo = WORD_MID;
			end
			PAT_ONES: begin
				wordOne = WORD_ONES;
				wordTwo = WORD_ONES;
			end
			PAT_ZEROS: begin
				wordOne = WORD_ZEROS;
				wordTwo = WORD_ZEROS;
			end
			PAT_CHECKER: begin
				wordOne = WORD_CHK1;
				wordTwo = WORD_CHK2;
			end
			PAT_ONE_ZERO: begin
				wordOne = WORD_ONES;
				wordTwo = WORD_ZEROS;
			end
			PAT_USER: begin
				wordOne = path.userWord1;
				wordTwo = path.userWord2;
			end
			default: begin
				valid = 1'b0; // off and reserved codes
			end
		endcase
	end

	// reserved mode values fall back to static
	assign altMode = (path.patMode == PMODE_ALT); // see [RQ14]

	// updates only on sample pulses, so a new setting waits for the next sample pulse
	always_comb begin
		stateD = stateQ;
		if (path.sampleEn) begin // see [RQ13]
			stateD.active = valid;
			if (altMode) begin
				stateD.phase = ~stateQ.phase; // see [RQ12]
			end else begin
				stateD.phase = 1'b0;
			end
			stateD.word = stateD.phase ? wordTwo : wordOne; // see [RQ12]
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			stateQ <= '0;
		end else begin
			stateQ <= stateD;
		end
	end

	assign path.testWord   = stateQ.word;
	assign path.testActive = stateQ.active;

endmodule : test_pattern_gen

// ===== logic/adc_global_config_test_regs.sv
// global configuration and test register set of the converter
// assumes the serial engine presents decoded byte writes and reads on clk,
// and the tri-level pins arrive as two-bit comparator levels, unsynchronised
`timescale 1ns/100ps

// What this block does
// [RQ1] divide-by-four slip advances divided edge one cycle
// [RQ2] host writes zero then one to slip bit
// [RQ3] divider field picks pin, one, two, four
// [RQ4] divider and format registers survive soft reset
// [RQ5] mode bits pick pin, diff 2mA, 3mA, CMOS
// [RQ6] format bits pick pin, twos, Gray, binary
// [RQ7] pin-control code takes setting from pins
// [RQ8] loop range bit six: fast default, slow
// [RQ9] host picks loop range to suit sample rate
// [RQ10] mode B with status sets DDR, loop
// [RQ11] host writes read-xor-xor value to mode B
// [RQ12] alternate mode swaps two words each phase
// [RQ13] test enable lags by several sample cycles; here it waits for the next sample pulse
// [RQ14] mode bits: static, alternate, others reserved
// [RQ15] low four bits select fixed or user pattern
// [RQ16] user words built from low, high byte pairs
// [RQ17] soft reset restores defaults except exempted registers
// [RQ18] slip only on zero-to-one, once each
module adc_global_config_test_regs
	import adc_cfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	output logic      [7:0]  regRdata,
	output logic             regRvalid,
	input  wire logic [1:0]  dividerPin,
	input  wire logic [1:0]  outputKindPin,
	input  wire logic [1:0]  codingPin,
	output divisor_t         divisor,
	output kind_t            outputKind,
	output coding_t          coding,
	output logic             ddrEnable,
	output logic             dllSlow,
	output logic             sampleEn,
	output logic             divClk,
	output logic [15:0]      testWord,
	output logic             testActive
);

	typedef struct packed {
		logic [7:0] portCfg;   // port configuration, soft reset self-clears
		logic [7:0] advance;   // divided clock advance
		logic [7:0] divSel;    // clock divisor select
		logic [7:0] fmtSel;    // output kind and coding
		logic [7:0] ddrStore;  // last value written to mode B
		logic [7:0] ddrEff;    // setting in force
		logic [7:0] patSel;    // pattern mode and choice
		logic [7:0] w1Low;     // user word one, low byte
		logic [7:0] w1High;    // user word one, high byte
		logic [7:0] w2Low;     // user word two, low byte
		logic [7:0] w2High;    // user word two, high byte
		logic [7:0] rdata;     // read answer
		logic       rvalid;    // read answer strobe
		logic       slip;      // advance request pulse
		logic [5:0] pinMeta;   // first synchroniser stage, three pins
		logic [5:0] pinSync;   // second synchroniser stage
		divisor_t   divisor;   // effective divisor
		kind_t      kind;      // effective output kind
		coding_t    coding;    // effective coding
	} reg_state_t;

	reg_state_t stateQ;      // registered state
	reg_state_t stateD;      // next state
	logic [1:0] rstSync;     // reset release synchroniser
	logic       rstLocal_n;  // synchronised reset
	logic [7:0] rdMux;       // read multiplexer
	logic [1:0] pinDiv;      // synchronised divider pin
	logic [1:0] pinKind;     // synchronised output kind pin
	logic [1:0] pinCode;     // synchronised coding pin

	sample_path_if path ();  // link to the helpers

	// release reset through two flops, assert at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync <= 2'b00;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstLocal_n = rstSync[1];

	assign pinDiv  = stateQ.pinSync[1:0];
	assign pinKind = stateQ.pinSync[3:2];
	assign pinCode = stateQ.pinSync[5:4];

	// read multiplexer; unmapped addresses read zero
	always_comb begin
		case (regAddr)
			ADDR_PORT_CFG: rdMux = stateQ.portCfg;
			ADDR_ADVANCE:  rdMux = stateQ.advance;
			ADDR_DIVISOR:  rdMux = stateQ.divSel;
			ADDR_FORMAT:   rdMux = stateQ.fmtSel;
			ADDR_DDR_LOOP: rdMux = stateQ.ddrStore;
			// status reads as the key that links store and setting
			ADDR_XOR_KEY:  rdMux = stateQ.ddrStore ^ stateQ.ddrEff;
			ADDR_PAT_SEL:  rdMux = stateQ.patSel;
			ADDR_W1_LOW:   rdMux = stateQ.w1Low;
			ADDR_W1_HIGH:  rdMux = stateQ.w1High;
			ADDR_W2_LOW:   rdMux = stateQ.w2Low;
			ADDR_W2_HIGH:  rdMux = stateQ.w2High;
			default:       rdMux = REG_RESET;
		endcase
	end

	// register writes, soft reset, synchronisers and decoded settings
	always_comb begin
		stateD         = stateQ;
		stateD.slip    = 1'b0;
		stateD.rvalid  = regRead;
		stateD.pinMeta = {codingPin, outputKindPin, dividerPin};
		stateD.pinSync = stateQ.pinMeta;
		if (regRead) begin
			stateD.rdata = rdMux;
		end
		if (regWrite) begin
			case (regAddr)
				ADDR_PORT_CFG: stateD.portCfg = regWdata;
				ADDR_ADVANCE: begin
					stateD.advance = regWdata;
					// rising bit only; a repeated one does nothing
					stateD.slip = regWdata[ADVANCE_BIT] &
						~stateQ.advance[ADVANCE_BIT]; // see [RQ18] [RQ2]
				end
				ADDR_DIVISOR:  stateD.divSel = regWdata;
				ADDR_FORMAT:   stateD.fmtSel = regWdata;
				ADDR_DDR_LOOP: begin
					// setting toggles by the written value; see [RQ10] [RQ11]
					stateD.ddrStore = regWdata;
					stateD.ddrEff   = stateQ.ddrEff ^ regWdata;
				end
				ADDR_PAT_SEL:  stateD.patSel = regWdata;
				ADDR_W1_LOW:   stateD.w1Low  = regWdata;
				ADDR_W1_HIGH:  stateD.w1High = regWdata;
				ADDR_W2_LOW:   stateD.w2Low  = regWdata;
				ADDR_W2_HIGH:  stateD.w2High = regWdata;
				default: ; // status and unmapped writes are ignored
			endcase
		end
		// soft reset spares divider and format registers; see [RQ4]
		if (stateQ.portCfg[SOFT_RESET_BIT]) begin // see [RQ17]
			stateD.portCfg  = REG_RESET;
			stateD.advance  = REG_RESET;
			stateD.ddrStore = REG_RESET;
			stateD.ddrEff   = REG_RESET;
			stateD.patSel   = REG_RESET;
			stateD.w1Low    = REG_RESET;
			stateD.w1High   = REG_RESET;
			stateD.w2Low    = REG_RESET;
			stateD.w2High   = REG_RESET;
		end

		// divisor: explicit code or pin level; see [RQ3] [RQ7]
		case (stateQ.divSel[2:0])
			SEL_A: stateD.divisor = DIV_BY1;
			SEL_B: stateD.divisor = DIV_BY2;
			SEL_C: stateD.divisor = DIV_BY4;
			default: begin
				case (pinDiv)
					PIN_MID:  stateD.divisor = DIV_BY2;
					PIN_HIGH: stateD.divisor = DIV_BY4;
					default:  stateD.divisor = DIV_BY1;
				endcase
			end
		endcase

		// output kind; see [RQ5] [RQ7]
		case (stateQ.fmtSel[KIND_LSB +: 3])
			SEL_A: stateD.kind = KIND_DIFF2;
			SEL_B: stateD.kind = KIND_DIFF3;
			SEL_C: stateD.kind = KIND_CMOS;
			default: begin
				case (pinKind)
					PIN_MID:  stateD.kind = KIND_DIFF3;
					PIN_HIGH: stateD.kind = KIND_CMOS;
					default:  stateD.kind = KIND_DIFF2;
				endcase
			end
		endcase

		// data coding; see [RQ6] [RQ7]
		case (stateQ.fmtSel[2:0])
			SEL_A: stateD.coding = CODE_TWOS;
			SEL_B: stateD.coding = CODE_GRAY;
			SEL_C: stateD.coding = CODE_BINARY;
			default: begin
				case (pinCode)
					PIN_MID:  stateD.coding = CODE_GRAY;
					PIN_HIGH: stateD.coding = CODE_BINARY;
					default:  stateD.coding = CODE_TWOS;
				endcase
			end
		endcase
	end

	// state register; all registers clear to their defaults
	always_ff @(posedge clk or negedge rstLocal_n) begin
		if (!rstLocal_n) begin
			stateQ         <= '0;
			stateQ.divisor <= DIV_BY1;
			stateQ.kind    <= KIND_DIFF2;
			stateQ.coding  <= CODE_TWOS;
		end else begin
			stateQ <= stateD;
		end
	end

	// settings handed to the helpers
	assign path.divisor   = stateQ.divisor;
	assign path.slipReq   = stateQ.slip; // see [RQ1]
	assign path.patMode   = stateQ.patSel[PMODE_LSB +: 2];
	assign path.patSel    = stateQ.patSel[3:0];
	assign path.userWord1 = {stateQ.w1High, stateQ.w1Low}; // see [RQ16]
	assign path.userWord2 = {stateQ.w2High, stateQ.w2Low}; // see [RQ16]

	// divided timing
	clock_divider_slip divider (
		.clk        (clk),
		.rstLocal_n (rstLocal_n),
		.path       (path)
	);

	// test patterns
	test_pattern_gen pattern (
		.clk        (clk),
		.rstLocal_n (rstLocal_n),
		.path       (path)
	);

	// outputs, all straight from flops
	assign regRdata   = stateQ.rdata;
	assign regRvalid  = stateQ.rvalid;
	assign divisor    = stateQ.divisor;
	assign outputKind = stateQ.kind;
	assign coding     = stateQ.coding;
	assign ddrEnable  = stateQ.ddrEff[DDR_EN_BIT];
	// zero means fast, so reset gives the fast range; see [RQ8]
	assign dllSlow    = stateQ.ddrEff[DLL_SLOW_BIT];
	assign sampleEn   = path.sampleEn;
	assign divClk     = path.divClk;
	assign testWord   = path.testWord;
	assign testActive = path.testActive;

endmodule : adc_global_config_test_regs

// ===== dv/adc_global_config_test_regs_sva.sv
// port assertions for the configuration and test register set
// assumes it is bound into the top module and shares its clock
`timescale 1ns/100ps
module adc_global_config_test_regs_chk
	import adc_cfg_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWdata,
	input wire logic [7:0]  regRdata,
	input wire logic        regRvalid,
	input wire logic [1:0]  dividerPin,
	input wire logic [1:0]  outputKindPin,
	input wire logic [1:0]  codingPin,
	input wire divisor_t    divisor,
	input wire kind_t       outputKind,
	input wire coding_t     coding,
	input wire logic        ddrEnable,
	input wire logic        dllSlow,
	input wire logic        sampleEn,
	input wire logic        divClk,
	input wire logic [15:0] testWord,
	input wire logic        testActive
);
	wire logic slowBit = regWdata[DLL_SLOW_BIT]; // loop range bit of a write
	wire logic ddrBit  = regWdata[DDR_EN_BIT];   // ddr bit of a write

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// read answer exactly one cycle after the strobe
	AST_READ_ANSWER: assert property (regRead |=> regRvalid)
		else $error("read answer missing");
	AST_NO_STRAY_ANSWER: assert property (!regRead |=> !regRvalid)
		else $error("read answer without a read");
	// pattern word only moves after a sample pulse
	AST_WORD_ON_SAMPLE: assert property (
		$changed(testWord) |-> $past(sampleEn))
		else $error("test word moved off a sample pulse");
	// quiet port: divide-by-four pulses are four cycles apart
	AST_DIV4_PERIOD: assert property (
		!regWrite [*2] ##1 (sampleEn && !regWrite && divisor == DIV_BY4)
		##1 (!regWrite && divisor == DIV_BY4) [*3] |=> sampleEn)
		else $error("divide-by-four period is not four cycles");
	AST_DIVISOR_DECODE: assert property (
		regWrite && regAddr == ADDR_DIVISOR && regWdata[2:0] == SEL_C
		|-> ##2 divisor == DIV_BY4)
		else $error("divisor code four not decoded");
	AST_KIND_DECODE: assert property (
		regWrite && regAddr == ADDR_FORMAT && regWdata[7:5] == SEL_C
		|-> ##2 outputKind == KIND_CMOS)
		else $error("single-ended output code not decoded");
	AST_CODING_DECODE: assert property (
		regWrite && regAddr == ADDR_FORMAT && regWdata[2:0] == SEL_B
		|-> ##2 coding == CODE_GRAY)
		else $error("gray coding code not decoded");
	// a mode B write flips the effective bits it carries
	AST_LOOP_XOR: assert property (
		!regWrite ##1 regWrite && regAddr == ADDR_DDR_LOOP ##1 !regWrite
		|=> dllSlow == ($past(dllSlow, 2) ^ $past(slowBit, 2))
		&& ddrEnable == ($past(ddrEnable, 2) ^ $past(ddrBit, 2)))
		else $error("mode B write did not xor the effective bits");
	AST_SOFT_CLEARS_LOOP: assert property (
		regWrite && regAddr == ADDR_PORT_CFG && regWdata[SOFT_RESET_BIT]
		##1 !regWrite [*2] |=> !dllSlow && !ddrEnable)
		else $error("soft reset left loop settings");
endmodule : adc_global_config_test_regs_chk

bind adc_global_config_test_regs adc_global_config_test_regs_chk chk (
	.clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
	.regRvalid, .dividerPin, .outputKindPin, .codingPin, .divisor,
	.outputKind, .coding, .ddrEnable, .dllSlow, .sampleEn, .divClk,
	.testWord, .testActive);

// ===== dv/serial_host_model.sv
// host side of the register port: byte writes and reads
// assumes the bench calls its tasks and clk is the design clock
`timescale 1ns/100ps
module serial_host_model
	import adc_cfg_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] regRdata,
	input  wire logic       regRvalid,
	output logic            regWrite,
	output logic            regRead,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWdata
);
	logic rvalidSeen; // answer strobe seen on the last read

	// idle port from time zero
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'hFF;
		regWdata = 8'hFF;
		rvalidSeen = 1'b0;
	end

	// one byte write, launched and released at falling edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clk);
		regWrite = 1'b0;
		// released lines never keep the old byte
		regAddr = ~a;
		regWdata = ~d;
	endtask : wr

	// one byte read; the answer stands for the cycle after the read edge,
	// so it is taken mid-cycle before the lines are released
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge clk);
		d = regRdata;
		rvalidSeen = regRvalid;
		regRead = 1'b0;
		regAddr = ~a;
	endtask : rd

	// zero then one on the advance bit, as two separate writes
	task automatic slip();
		wr(ADDR_ADVANCE, 8'h00);
		wr(ADDR_ADVANCE, 8'h01);
	endtask : slip

	// mode B goes through the read, xor, xor, write procedure
	task automatic setLoop(input logic [7:0] want);
		logic [7:0] cur;
		logic [7:0] key;
		rd(ADDR_DDR_LOOP, cur);
		rd(ADDR_XOR_KEY, key);
		wr(ADDR_DDR_LOOP, cur ^ key ^ want);
	endtask : setLoop
endmodule : serial_host_model

// ===== dv/adc_global_config_test_regs_tb_top.sv
// self-checking bench for the configuration and test register set
// assumes the host model drives the port at falling clock edges
`timescale 1ns/100ps
module adc_global_config_test_regs_tb_top
	import adc_cfg_pkg::*;
;
	logic        clk, rst_n, regWrite, regRead, regRvalid;
	logic [1:0]  dividerPin, outputKindPin, codingPin; // tri-level levels
	logic [7:0]  regAddr, regWdata, regRdata, rd8;
	logic        ddrEnable, dllSlow, sampleEn, divClk, testActive;
	divisor_t    divisor;
	kind_t       outputKind;
	coding_t     coding;
	logic [15:0] testWord;
	int          failures, checks, n;
	// loop settings; slow range assumes 40 to 100 MSPS sampling
	logic [7:0]  want[4] = '{8'h40, 8'h50, 8'h10, 8'h00};
	logic [3:0]  patCode[8] = '{PAT_MID, PAT_ONES, PAT_ZEROS, PAT_CHECKER,
		PAT_ONE_ZERO, PAT_USER, PAT_OFF, 4'h5};
	logic [15:0] patWord[8] = '{WORD_MID, WORD_ONES, WORD_ZEROS, WORD_CHK1,
		WORD_ONES, 16'h1234, WORD_ZEROS, WORD_ZEROS};

	initial clk = 1'b0;
	always #4 clk = ~clk;

	adc_global_config_test_regs dut (.clk, .rst_n, .regWrite, .regRead,
		.regAddr, .regWdata, .regRdata, .regRvalid, .dividerPin,
		.outputKindPin, .codingPin, .divisor, .outputKind, .coding,
		.ddrEnable, .dllSlow, .sampleEn, .divClk, .testWord, .testActive);
	serial_host_model host (.clk, .regRdata, .regRvalid, .regWrite,
		.regRead, .regAddr, .regWdata);

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : settle

	// cycles taken until k more sample pulses are seen
	task automatic span(input int k, output int cnt);
		cnt = 0;
		while (k > 0) begin
			@(posedge clk);
			#1;
			cnt++;
			if (sampleEn === 1'b1) k--;
		end
	endtask : span

	// two alternating words, any starting phase
	task automatic alt(input logic [3:0] c, input logic [15:0] w1, w2);
		logic [15:0] a;
		host.wr(ADDR_PAT_SEL, {PMODE_ALT, 2'b00, c});
		settle(12);
		a = testWord;
		settle(1);
		chk(16'((a === w1 && testWord === w2) ||
			(a === w2 && testWord === w1)), 16'h0001);
		settle(1);
		chk(testWord, a);
	endtask : alt

	initial begin
		rst_n = 1'b0;
		dividerPin = PIN_HIGH;
		outputKindPin = PIN_MID;
		codingPin = PIN_MID;
		failures = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		settle(8);
		chk(16'(divisor), 16'(DIV_BY4));
		chk(16'(outputKind), 16'(KIND_DIFF3));
		chk(16'(coding), 16'(CODE_GRAY));
		chk(16'(dllSlow), 16'h0000);
		// every one-hot select code of divisor, kind and coding
		for (int i = 0; i < 3; i++) begin
			host.wr(ADDR_DIVISOR, 8'(SEL_A << i));
			host.wr(ADDR_FORMAT, {3'(SEL_A << i), 2'b00, 3'(SEL_C >> i)});
			settle(3);
			chk(16'(divisor), 16'(i));
			chk(16'(outputKind), 16'(i));
			chk(16'(coding), 16'(2 - i));
		end
		// soft reset spares divisor and format only
		host.wr(ADDR_W1_LOW, 8'h5A);
		host.wr(ADDR_PORT_CFG, 8'h20);
		settle(3);
		host.rd(ADDR_DIVISOR, rd8);
		chk(16'(rd8), 16'h0004);
		host.rd(ADDR_FORMAT, rd8);
		chk(16'(rd8), 16'h0081);
		host.rd(ADDR_W1_LOW, rd8);
		chk(16'(rd8), 16'h0000);
		host.rd(8'h03, rd8);
		chk(16'(rd8), 16'h0000);
		chk(16'(host.rvalidSeen), 16'h0001);
		for (int i = 0; i < 4; i++) begin
			host.setLoop(want[i]);
			settle(3);
			chk(16'({dllSlow, ddrEnable}),
				16'({want[i][6], want[i][4]}));
		end
		// patterns at divide-by-one, one sample each cycle
		host.wr(ADDR_DIVISOR, 8'(SEL_A));
		host.wr(ADDR_W1_LOW, 8'h34);
		host.wr(ADDR_W1_HIGH, 8'h12);
		host.wr(ADDR_W2_LOW, 8'hCD);
		host.wr(ADDR_W2_HIGH, 8'hAB);
		for (int i = 0; i < 8; i++) begin
			host.wr(ADDR_PAT_SEL, {PMODE_STATIC, 2'b00, patCode[i]});
			settle(12);
			chk(testWord, patWord[i]);
			chk(16'(testActive), 16'(i < 6));
			settle(1);
			chk(testWord, patWord[i]);
		end
		alt(PAT_CHECKER, WORD_CHK1, WORD_CHK2);
		alt(PAT_USER, 16'h1234, 16'hABCD);
		// advance in divide-by-four: three periods lose one cycle
		host.wr(ADDR_DIVISOR, 8'(SEL_C));
		settle(4);
		span(1, n);
		chk(16'(divClk), 16'h0001);
		fork
			span(3, n);
			host.slip();
		join
		chk(16'(n), 16'h000B);
		// bit already set: no second advance
		span(1, n);
		fork
			span(3, n);
			host.wr(ADDR_ADVANCE, 8'h01);
		join
		chk(16'(n), 16'h000C);
		// divide-by-two ignores the advance
		host.wr(ADDR_DIVISOR, 8'(SEL_B));
		settle(4);
		span(1, n);
		chk(16'(divClk), 16'h0001);
		fork
			span(3, n);
			host.slip();
		join
		chk(16'(n), 16'h0006);
		conclude();
	end

	// tests need under 3000 cycles; this cuts a hang short
	initial begin
		#200000;
		failures++;
		conclude();
	end
endmodule : adc_global_config_test_regs_tb_top
